/* rtl/jie_pkg.sv */
// Package of encodings, field positions and phase constants for the jump and increment executor
package jie_pkg;
	localparam int INSTR_W = 14;
	localparam int PC_W = 13;
	localparam int DATA_W = 8;
	localparam int FADDR_W = 7;
	localparam int LIT_W = 11;
	// Opcode patterns
	localparam logic [2:0] JUMP_OPC = 3'h5;
	localparam int JUMP_OPC_LSB = 11;
	localparam logic [5:0] INCR_OPC = 6'h0A;
	localparam int INCR_OPC_LSB = 8;
	localparam int DEST_BIT = 7;
	// Upper latch field feeding program counter top bits
	localparam int LATCH_HI = 4;
	localparam int LATCH_LO = 3;
	localparam logic [7:0] ZERO_BYTE = 8'h00;
	localparam logic [7:0] ONE_BYTE = 8'h01;
	localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
	typedef enum logic [1:0] {
		JIE_Q1 = 2'b00,
		JIE_Q2 = 2'b01,
		JIE_Q3 = 2'b11,
		JIE_Q4 = 2'b10
	} jie_phase_e;
endpackage : jie_pkg

/* rtl/jie_quarter_gen.sv */
// Quarter phase generator dividing each instruction cycle into four phases
`timescale 1ns/1ns
module jie_quarter_gen
	import jie_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// Phase
	output jie_phase_e phase
);
	jie_phase_e next_phase;

	always_comb begin
		case (phase)
			JIE_Q1: next_phase = JIE_Q2;
			JIE_Q2: next_phase = JIE_Q3;
			JIE_Q3: next_phase = JIE_Q4;
			JIE_Q4: next_phase = JIE_Q1;
			default: next_phase = JIE_Q1;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			phase <= JIE_Q1;
		end else begin
			phase <= next_phase;
		end
	end
endmodule : jie_quarter_gen

/* rtl/jie_exec.sv */
// Decode and execute of the absolute jump and the file increment instructions
//
// Summary of operation
// - The absolute jump loads its 11-bit literal into program counter bits 10 to 0.
// - The absolute jump copies upper latch bits 4 and 3 into program counter bits 12 and 11.
// - The absolute jump takes two instruction cycles, the second idle, and changes no status flag.
// - The file increment adds one to the register and writes the accumulator when d is 0, the register when d is 1.
// - The file increment finishes in one cycle: decode, read, process, write in phases one to four.
`timescale 1ns/1ns
module jie_exec
	import jie_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// Instruction fetched for the cycle, sampled at phase one
	input wire logic [INSTR_W-1:0] instr,
	input wire logic [DATA_W-1:0] pcUpperLatch,
	// File register port
	output logic [FADDR_W-1:0] fileAddr,
	output logic fileRead,
	input wire logic [DATA_W-1:0] fileRdata,
	output logic fileWrite,
	output logic [DATA_W-1:0] fileWdata,
	// Core state
	output logic [PC_W-1:0] pc,
	output logic [DATA_W-1:0] accum,
	output logic zeroFlag,
	output jie_phase_e phase,
	output logic idleCycle
);
	////////////////////////////////////////////////////////////////////////////
	logic [INSTR_W-1:0] ir;
	logic [DATA_W-1:0] operand;
	logic [DATA_W-1:0] result;
	logic isJump;
	logic isIncr;
	logic destFile;
	logic [PC_W-1:0] jumpTarget;
	logic [DATA_W-1:0] sum;

	jie_quarter_gen u_quarter (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.phase(phase)
	);

	function automatic logic decJump(input logic [INSTR_W-1:0] w);
		decJump = (w[INSTR_W-1:JUMP_OPC_LSB] == JUMP_OPC);
	endfunction : decJump

	function automatic logic decIncr(input logic [INSTR_W-1:0] w);
		decIncr = (w[INSTR_W-1:INCR_OPC_LSB] == INCR_OPC);
	endfunction : decIncr

	// Idle cycle executes nothing regardless of the latched word
	assign isJump = decJump(ir) && !idleCycle;
	assign isIncr = decIncr(ir) && !idleCycle;
	assign destFile = ir[DEST_BIT];
	assign jumpTarget = {pcUpperLatch[LATCH_HI:LATCH_LO], ir[LIT_W-1:0]};
	assign sum = operand + ONE_BYTE;
	assign fileAddr = ir[FADDR_W-1:0];
	assign fileRead = isIncr && (phase == JIE_Q2);
	assign fileWrite = isIncr && destFile && (phase == JIE_Q4);
	assign fileWdata = result;

	////////////////////////////////////////////////////////////////////////////
	// Decode at Q1; ir holds for the rest of the cycle
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			ir <= '0;
		end else if (phase == JIE_Q1) begin
			ir <= instr;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			operand <= ZERO_BYTE;
		end else if (fileRead) begin
			operand <= fileRdata;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			result <= ZERO_BYTE;
		end else if (isIncr && phase == JIE_Q3) begin
			result <= sum;
		end
	end

	// Zero flag and accumulator update at Q4 only
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			accum <= ZERO_BYTE;
			zeroFlag <= 1'b0;
		end else if (isIncr && phase == JIE_Q4) begin
			zeroFlag <= (result == ZERO_BYTE);
			if (!destFile) begin
				accum <= result;
			end
		end
	end

	// Jump writes PC at Q4 and forces the following cycle idle, since the prefetched word is stale
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			pc <= PC_RESET;
			idleCycle <= 1'b0;
		end else if (phase == JIE_Q4) begin
			idleCycle <= isJump;
			if (isJump) begin
				pc <= jumpTarget;
			end else begin
				pc <= pc + PC_W'(1);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	chk_jump_target: assert property (@(posedge sys_clk) disable iff (!resetn)
		(isJump && phase == JIE_Q4) |=> (pc == {$past(pcUpperLatch[LATCH_HI:LATCH_LO]), $past(ir[LIT_W-1:0])}))
		else $error("jump target wrong");
	chk_jump_idle: assert property (@(posedge sys_clk) disable iff (!resetn)
		(isJump && phase == JIE_Q4) |=> idleCycle[*4])
		else $error("jump second cycle not idle");
	chk_idle_quiet: assert property (@(posedge sys_clk) disable iff (!resetn)
		idleCycle |-> (!fileWrite && !fileRead && $stable(accum) && $stable(zeroFlag)))
		else $error("idle cycle did work");
	chk_jump_flags: assert property (@(posedge sys_clk) disable iff (!resetn)
		isJump |=> $stable(zeroFlag))
		else $error("jump changed zero flag");
	// During phase one ir still holds the previous word, so the decode is taken from the input
	chk_incr_phases: assert property (@(posedge sys_clk) disable iff (!resetn)
		(phase == JIE_Q1 && !idleCycle && decIncr(instr)) |=> (fileRead && fileAddr == $past(instr[FADDR_W-1:0]))
		##1 !fileRead ##1 (fileWrite == $past(instr[DEST_BIT], 3)))
		else $error("increment phase order broken");
	chk_incr_accum: assert property (@(posedge sys_clk) disable iff (!resetn)
		(fileRead && !destFile) |=> ##2 (accum == $past(fileRdata, 3) + ONE_BYTE))
		else $error("accumulator result wrong");
	chk_incr_wdata: assert property (@(posedge sys_clk) disable iff (!resetn)
		(fileRead && destFile) |=> ##1 (fileWrite && fileWdata == $past(fileRdata, 2) + ONE_BYTE))
		else $error("file write data wrong");
	chk_incr_zero: assert property (@(posedge sys_clk) disable iff (!resetn)
		(isIncr && phase == JIE_Q4) |=> (zeroFlag == (fileWdata == ZERO_BYTE)))
		else $error("zero flag wrong");
	chk_zero_hold: assert property (@(posedge sys_clk) disable iff (!resetn)
		!(isIncr && phase == JIE_Q4) |=> $stable(zeroFlag))
		else $error("zero flag changed outside increment");
	chk_accum_hold: assert property (@(posedge sys_clk) disable iff (!resetn)
		!(isIncr && !destFile && phase == JIE_Q4) |=> $stable(accum))
		else $error("accumulator changed without increment");
	chk_pc_step: assert property (@(posedge sys_clk) disable iff (!resetn)
		(phase == JIE_Q4 && !isJump) |=> (pc == $past(pc) + PC_W'(1)))
		else $error("program counter step wrong");
	chk_idle_clear: assert property (@(posedge sys_clk) disable iff (!resetn)
		(idleCycle && phase == JIE_Q4) |=> !idleCycle)
		else $error("idle cycle lasted too long");
	chk_write_addr: assert property (@(posedge sys_clk) disable iff (!resetn)
		(phase == JIE_Q1 && !idleCycle && decIncr(instr) && instr[DEST_BIT])
		|=> ##2 (fileWrite && fileAddr == $past(instr[FADDR_W-1:0], 3)))
		else $error("file write missing or misaddressed");
endmodule : jie_exec

/* bench/jump_and_increment_exec_bench.sv */
// Self-checking bench for the jump and increment executor
`timescale 1ns/1ns
module jump_and_increment_exec_bench import jie_pkg::*;;
typedef struct packed {logic rd, wr, idle, z; logic [6:0] addr; logic [7:0] wdata, acc; logic [12:0] pc;} jie_note_s;
logic sys_clk = 0, resetn = 0, zeroFlag, fileRead, fileWrite, idleCycle;
logic [13:0] instr = 0;
logic [7:0] pcUpperLatch = 0, fileRdata = 0, fileWdata, accum;
logic [6:0] fileAddr;
logic [12:0] pc;
jie_phase_e phase;
jie_note_s notes[$], m, e;
int n_errors = 0, checks = 0, seed = 45;
always #4 sys_clk = ~sys_clk;
jie_exec dut(.sys_clk(sys_clk), .resetn(resetn), .instr(instr), .pcUpperLatch(pcUpperLatch), .fileAddr(fileAddr),
	.fileRead(fileRead), .fileRdata(fileRdata), .fileWrite(fileWrite), .fileWdata(fileWdata), .pc(pc),
	.accum(accum), .zeroFlag(zeroFlag), .phase(phase), .idleCycle(idleCycle));
////////////////////////////////////////////////////////////////
task cmp(input string what, input logic [12:0] exp, input logic [12:0] got);
	checks++;
	if (got !== exp) begin
		n_errors++;
		$display("MISMATCH %s expected %h seen %h", what, exp, got);
	end
endtask : cmp
task end_of_test;
	if (n_errors == 0 && checks > 0) $display("All tests passed");
	else $display("Some tests failed");
	$finish;
endtask : end_of_test
// Present one instruction at Q1 and note its effect; the idle cycle ignores whatever is presented
task step(input logic [13:0] op, input logic [7:0] rd);
	logic [7:0] r;
	r = rd + 8'h01;
	instr = op;
	pcUpperLatch = 8'($random(seed));
	m.rd = 0;
	m.wr = 0;
	m.pc = m.pc + 13'h0001;
	if (m.idle) m.idle = 0;
	else if (op[13:11] == JUMP_OPC) begin
		m.pc = {pcUpperLatch[LATCH_HI:LATCH_LO], op[10:0]};
		m.idle = 1;
	end else if (op[13:8] == INCR_OPC) begin
		m.rd = 1;
		m.addr = op[6:0];
		m.wr = op[DEST_BIT];
		m.wdata = r;
		m.z = (r == ZERO_BYTE);
		if (!op[DEST_BIT]) m.acc = r;
	end
	notes.push_back(m);
	@(negedge sys_clk) fileRdata = rd;
	repeat (3) @(negedge sys_clk);
endtask : step
////////////////////////////////////////////////////////////////
always @(negedge sys_clk) if (resetn && phase === JIE_Q2 && notes.size() > 0) begin
	e = notes.pop_front();
	cmp("fileRead", 13'(e.rd), 13'(fileRead));
	if (e.rd) cmp("fileAddr", 13'(e.addr), 13'(fileAddr));
	repeat (2) @(negedge sys_clk);
	cmp("fileWrite", 13'(e.wr), 13'(fileWrite));
	if (e.wr) cmp("fileWdata", 13'(e.wdata), 13'(fileWdata));
	@(negedge sys_clk);
	cmp("pc", e.pc, pc);
	cmp("accum", 13'(e.acc), 13'(accum));
	cmp("zeroFlag", 13'(e.z), 13'(zeroFlag));
	cmp("idleCycle", 13'(e.idle), 13'(idleCycle));
end
initial begin
	logic [13:0] op;
	m = '0;
	repeat (12) @(negedge sys_clk);
	resetn = 1;
	step({JUMP_OPC, 11'h7FF}, 8'h00);
	step({INCR_OPC, 1'b0, 7'h7F}, 8'hFF);
	step({INCR_OPC, 1'b0, 7'h7F}, 8'hFF);
	step({INCR_OPC, 1'b1, 7'h7F}, 8'hFF);
	for (int i = 0; i < 60; i++) begin
		op = 14'($random(seed));
		case (op[1:0])
			2'h0: op[13:11] = JUMP_OPC;
			2'h1, 2'h2: op[13:8] = INCR_OPC;
			default: op[13:12] = 2'h3;
		endcase
		step(op, op[2] ? 8'hFF : 8'($random(seed)));
	end
	repeat (4) @(negedge sys_clk);
	end_of_test();
end
// Run needs about 270 clocks; allow ample margin
initial begin
	#(8 * 1000);
	n_errors++;
	end_of_test();
end
endmodule : jump_and_increment_exec_bench
